// [core/disp_ram.sv]
/*
  Display RAM: one write port and one registered read port.
  Assumes the caller presents a row and column address on the same cycle as
  the strobe; read data appears one cycle after the read strobe.
*/
`timescale 1ns/1ps
module disp_ram #(
  parameter int unsigned ROWS  = 64,
  parameter int unsigned COLS  = 128,
  parameter int unsigned ROW_W = 6,
  parameter int unsigned COL_W = 7
) (
  // Clock.
  input  wire logic             sys_clk,
  // Write port.
  input  wire logic             we,
  input  wire logic [ROW_W-1:0] wrow,
  input  wire logic [COL_W-1:0] wcol,
  input  wire logic [7:0]       wdata,
  // Read port.
  input  wire logic             re,
  input  wire logic [ROW_W-1:0] rrow,
  input  wire logic [COL_W-1:0] rcol,
  output logic      [7:0]       rdata_q
);

  // Every row and column code must hit a real word.
  if (ROWS != (1 << ROW_W) || COLS != (1 << COL_W)) begin : g_bad_size
    $error("Display RAM size does not match its address widths.");
  end

  // No reset on the array: its contents are undefined after power-up anyway.
  logic [7:0] mem [ROWS*COLS];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[{wrow, wcol}] <= wdata;
    end
    if (re) begin
      rdata_q <= mem[{rrow, rcol}];
    end
  end

endmodule

// [core/oled_cmd_decoder.sv]
/*
  Command decoder and display-RAM access logic of a grayscale OLED controller.
  Assumes the host interface front end has already turned bus cycles into
  one-cycle strobes synchronous to sys_clk, with at most one strobe a cycle.
*/
`timescale 1ns/1ps
module oled_cmd_decoder #(
  parameter int unsigned ROWS = 64,
  parameter int unsigned COLS = 128
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Host access strobes.
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic       cmd_data_select,
  input  wire logic [7:0] wr_data,
  input  wire logic       serial_mode,
  input  wire logic       internal_busy,
  // Read answer.
  output logic      [7:0] rd_data_q,
  output logic            rd_valid_q,
  output logic            cmd_rejected_q,
  output logic            busy_q,
  // Address and mode state.
  output logic      [6:0] column_addr_q,
  output logic      [5:0] row_addr_q,
  output logic            rmw_active_q,
  // Display settings.
  output logic      [5:0] start_line_q,
  output logic      [7:0] contrast_q,
  output logic            seg_remap_q,
  output logic      [5:0] mux_ratio_q,
  output logic      [7:0] dcdc_ctrl_q,
  output logic      [5:0] display_offset_q,
  output logic      [7:0] clk_div_q,
  output logic      [7:0] pre_period_q,
  output logic      [7:0] vcom_level_q,
  output logic      [7:0] pre_level_q,
  output logic      [3:0] segment_discharge_level_q,
  output logic            display_on_q,
  output logic            scan_reverse_q
);

  if (ROWS != (1 << oled_cmd_pkg::ROW_W) || COLS != (1 << oled_cmd_pkg::COL_W)) begin : g_bad_size
    $error("Decoder supports only the documented RAM geometry.");
  end

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    oled_cmd_pkg::phase_t                  phase;
    logic [7:0]                            pend_op;
    logic [oled_cmd_pkg::COL_W-1:0]        col;
    logic [oled_cmd_pkg::COL_W-1:0]        col_saved;
    logic                                  rmw;
    logic [oled_cmd_pkg::ROW_W-1:0]        row;
    logic [5:0]                            start_line;
    logic [7:0]                            contrast;
    logic                                  seg_remap;
    logic [5:0]                            mux;
    logic [7:0]                            dcdc;
    logic [5:0]                            offset;
    logic [7:0]                            clk_div;
    logic [7:0]                            pre_period;
    logic [7:0]                            vcom;
    logic [7:0]                            pre_level;
    logic [3:0]                            dis_level;
    logic                                  disp_on;
    logic                                  scan_rev;
    logic [oled_cmd_pkg::BUSY_CNT_W-1:0]   busy_cnt;
    logic                                  busy;
    logic                                  rd_pend;
    logic                                  rd_stat;
    logic [7:0]                            rd_data;
    logic                                  rd_valid;
    logic                                  rejected;
  } state_t;

  state_t     q;
  state_t     d;
  logic [7:0] ram_rdata;
  logic       ram_we;
  logic       ram_re;
  logic       cmd_wr;
  logic       data_wr;
  logic       data_rd;

  assign cmd_wr  = wr_stb && !cmd_data_select;
  assign data_wr = wr_stb && cmd_data_select;
  // A write in the same cycle wins; the front end never issues both.
  assign data_rd = rd_stb && !wr_stb && cmd_data_select && !serial_mode;
  assign ram_we  = data_wr;
  assign ram_re  = data_rd;

  disp_ram #(
    .ROWS  (ROWS),
    .COLS  (COLS),
    .ROW_W (oled_cmd_pkg::ROW_W),
    .COL_W (oled_cmd_pkg::COL_W)
  ) u_ram (
    .sys_clk (sys_clk),
    .we      (ram_we),
    .wrow    (q.row),
    .wcol    (q.col),
    .wdata   (wr_data),
    .re      (ram_re),
    .rrow    (q.row),
    .rcol    (q.col),
    .rdata_q (ram_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    d          = q;
    d.rejected = 1'b0;
    d.rd_valid = 1'b0;
    d.rd_pend  = 1'b0;
    if (q.busy_cnt != '0) begin
      d.busy_cnt = q.busy_cnt - 1'b1;
    end
    if (cmd_wr && q.busy) begin
      d.rejected = 1'b1;
    end else if (cmd_wr && q.phase == oled_cmd_pkg::PH_PARAM) begin
      d.phase = oled_cmd_pkg::PH_CMD;
      unique case (q.pend_op)
        oled_cmd_pkg::CMD_CONTRAST:   d.contrast   = wr_data;
        oled_cmd_pkg::CMD_MUX_RATIO:  d.mux        = wr_data[5:0];
        oled_cmd_pkg::CMD_DCDC:       d.dcdc       = wr_data;
        oled_cmd_pkg::CMD_ROW_ADDR:   d.row        = wr_data[5:0];
        oled_cmd_pkg::CMD_OFFSET:     d.offset     = wr_data[5:0];
        oled_cmd_pkg::CMD_CLK_DIV:    d.clk_div    = wr_data;
        oled_cmd_pkg::CMD_PRE_PERIOD: d.pre_period = wr_data;
        oled_cmd_pkg::CMD_VCOM_LEVEL: d.vcom       = wr_data;
        oled_cmd_pkg::CMD_PRE_LEVEL:  d.pre_level  = wr_data;
        default:                      d.phase      = oled_cmd_pkg::PH_CMD;
      endcase
    end else if (cmd_wr) begin
      unique casez (wr_data)
        8'b0000_????: d.col[3:0]  = wr_data[3:0];
        8'b0001_????: d.col[6:4]  = wr_data[2:0];
        8'b0011_????: d.dis_level = wr_data[3:0];
        8'b01??_????: d.start_line = wr_data[5:0];
        8'b1010_000?: d.seg_remap = wr_data[0];
        8'b1010_111?: d.disp_on   = wr_data[0];
        8'b1100_????: d.scan_rev  = wr_data[3];
        oled_cmd_pkg::CMD_RMW_START: begin
          d.rmw       = 1'b1;
          d.col_saved = q.col;
        end
        oled_cmd_pkg::CMD_RMW_END: begin
          // An end without a start is harmless: the column is left alone.
          if (q.rmw) begin
            d.col = q.col_saved;
          end
          d.rmw = 1'b0;
        end
        oled_cmd_pkg::CMD_CONTRAST, oled_cmd_pkg::CMD_MUX_RATIO, oled_cmd_pkg::CMD_DCDC,
        oled_cmd_pkg::CMD_ROW_ADDR, oled_cmd_pkg::CMD_OFFSET, oled_cmd_pkg::CMD_CLK_DIV,
        oled_cmd_pkg::CMD_PRE_PERIOD, oled_cmd_pkg::CMD_VCOM_LEVEL,
        oled_cmd_pkg::CMD_PRE_LEVEL: begin
          d.phase   = oled_cmd_pkg::PH_PARAM;
          d.pend_op = wr_data;
        end
        default: d.phase = oled_cmd_pkg::PH_CMD;
      endcase
    end else if (data_wr) begin
      d.col = q.col + 1'b1;
    end else if (rd_stb && !cmd_data_select) begin
      d.rd_pend = 1'b1;
      d.rd_stat = 1'b1;
    end else if (data_rd) begin
      d.rd_pend = 1'b1;
      d.rd_stat = 1'b0;
      if (!q.rmw) begin
        d.col = q.col + 1'b1;
      end
    end
    if (q.rd_pend) begin
      d.rd_valid = 1'b1;
      if (q.rd_stat) begin
        d.rd_data                             = 8'h00;
        d.rd_data[oled_cmd_pkg::STAT_BUSY_BIT] = q.busy;
        d.rd_data[oled_cmd_pkg::STAT_OFF_BIT]  = !q.disp_on;
      end else begin
        d.rd_data = ram_rdata;
      end
    end
    d.busy = (d.busy_cnt != '0) || internal_busy;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q            <= '0;
      q.contrast   <= oled_cmd_pkg::POR_CONTRAST;
      q.mux        <= oled_cmd_pkg::POR_MUX_RATIO;
      q.dcdc       <= oled_cmd_pkg::POR_DCDC;
      q.clk_div    <= oled_cmd_pkg::POR_CLK_DIV;
      q.pre_period <= oled_cmd_pkg::POR_PRE_PERIOD;
      q.vcom       <= oled_cmd_pkg::POR_VCOM_LEVEL;
      q.pre_level  <= oled_cmd_pkg::POR_PRE_LEVEL;
      q.busy_cnt   <= oled_cmd_pkg::RESET_BUSY_CYCLES;
      q.busy       <= 1'b1;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign rd_data_q                 = q.rd_data;
  assign rd_valid_q                = q.rd_valid;
  assign cmd_rejected_q            = q.rejected;
  assign busy_q                    = q.busy;
  assign column_addr_q             = q.col;
  assign row_addr_q                = q.row;
  assign rmw_active_q              = q.rmw;
  assign start_line_q              = q.start_line;
  assign contrast_q                = q.contrast;
  assign seg_remap_q               = q.seg_remap;
  assign mux_ratio_q               = q.mux;
  assign dcdc_ctrl_q               = q.dcdc;
  assign display_offset_q          = q.offset;
  assign clk_div_q                 = q.clk_div;
  assign pre_period_q              = q.pre_period;
  assign vcom_level_q              = q.vcom;
  assign pre_level_q               = q.pre_level;
  assign segment_discharge_level_q = q.dis_level;
  assign display_on_q              = q.disp_on;
  assign scan_reverse_q            = q.scan_rev;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_precharge_level_param: assert property (
    cmd_wr && !q.busy && q.phase == oled_cmd_pkg::PH_PARAM && q.pend_op == oled_cmd_pkg::CMD_PRE_LEVEL
    |=> pre_level_q == $past(wr_data) && q.phase == oled_cmd_pkg::PH_CMD)
    else $error("Precharge level parameter not taken.");

  a_discharge_level_set: assert property (
    cmd_wr && !q.busy && q.phase == oled_cmd_pkg::PH_CMD && wr_data[7:4] == 4'h3
    |=> segment_discharge_level_q == $past(wr_data[3:0]))
    else $error("Discharge level not loaded.");

  a_rmw_read_hold: assert property (
    data_rd && q.rmw |=> column_addr_q == $past(column_addr_q))
    else $error("Column moved on a read in read-modify-write.");

  a_rmw_end_restore: assert property (
    cmd_wr && !q.busy && q.phase == oled_cmd_pkg::PH_CMD && wr_data == oled_cmd_pkg::CMD_RMW_END && q.rmw
    |=> column_addr_q == $past(q.col_saved) && !rmw_active_q)
    else $error("End did not restore the column.");

  a_write_col_advance: assert property (
    data_wr |=> column_addr_q == oled_cmd_pkg::COL_W'($past(column_addr_q) + 1'b1))
    else $error("Column did not advance after a data write.");

  a_status_off_flag: assert property (
    rd_stb && !wr_stb && !cmd_data_select |-> ##2 rd_valid_q && rd_data_q[2:0] == 3'b000
      && rd_data_q[oled_cmd_pkg::STAT_OFF_BIT] == !$past(display_on_q))
    else $error("Status byte wrong.");

  a_busy_reject: assert property (
    cmd_wr && q.busy |=> cmd_rejected_q && $stable(q.phase) && $stable(contrast_q) && $stable(column_addr_q))
    else $error("Command accepted while busy.");

  a_read_answer: assert property (
    data_rd |-> ##2 rd_valid_q)
    else $error("Data read gave no answer.");

  a_serial_no_read: assert property (
    rd_stb && !wr_stb && cmd_data_select && serial_mode |-> ##2 !rd_valid_q)
    else $error("Data read answered on serial interface.");

  a_column_low_load: assert property (
    cmd_wr && !q.busy && q.phase == oled_cmd_pkg::PH_CMD && wr_data[7:4] == 4'h0
    |=> column_addr_q[3:0] == $past(wr_data[3:0]))
    else $error("Low column bits not loaded.");

  a_param_phase_entry: assert property (
    cmd_wr && !q.busy && q.phase == oled_cmd_pkg::PH_CMD && wr_data == oled_cmd_pkg::CMD_OFFSET
    |=> q.phase == oled_cmd_pkg::PH_PARAM ##0 $stable(display_offset_q))
    else $error("Two-byte command did not await its parameter.");

endmodule

// [dv/host_model.sv]
/*
  Host model: drives the decoder's access strobes the way a microprocessor does.
  Assumes it shares sys_clk with the decoder and that the bench calls its tasks.
*/
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  wire logic       sys_clk,
  // Strobes towards the decoder.
  output logic            wr_stb,
  output logic            rd_stb,
  output logic            cmd_data_select,
  output logic      [7:0] wr_data,
  output logic            serial_mode,
  output logic            internal_busy,
  // Read answer.
  input  wire logic [7:0] rd_data_q,
  input  wire logic       rd_valid_q
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_data_select = 1'b0;
    wr_data = 8'h00;
    serial_mode = 1'b0;
    internal_busy = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The bench hands only defined codes to this task.
  task automatic put(input logic cds, input logic [7:0] data);
    @(posedge sys_clk);
    wr_stb <= 1'b1;
    cmd_data_select <= cds;
    wr_data <= data;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    // Released data lines show the inverse, so a stale byte never looks fresh.
    wr_data <= ~data;
  endtask

  task automatic get(input logic cds, output logic [7:0] data, output logic ok);
    ok = 1'b0;
    data = 8'h00;
    @(posedge sys_clk);
    rd_stb <= 1'b1;
    cmd_data_select <= cds;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      if (rd_valid_q === 1'b1 && !ok) begin
        ok = 1'b1;
        data = rd_data_q;
      end
    end
  endtask

  task automatic set_lines(input logic ser, input logic bsy);
    @(posedge sys_clk);
    serial_mode <= ser;
    internal_busy <= bsy;
  endtask
endmodule

// [dv/tb_oled_cmd_decoder.sv]
/*
  Self-checking bench of the OLED command decoder, driven through host_model.
  Assumes the decoder as declared in core/ and the package in inc/.
*/
`timescale 1ns/1ps
module tb_oled_cmd_decoder;
  logic       sys_clk;
  logic       rst_n;
  logic       wr_stb, rd_stb, cds, serial_mode, internal_busy;
  logic [7:0] wr_data, rd_data_q, contrast_q, dcdc_ctrl_q, clk_div_q;
  logic [7:0] pre_period_q, vcom_level_q, pre_level_q;
  logic       rd_valid_q, cmd_rejected_q, busy_q, rmw_active_q, seg_remap_q, display_on_q, scan_reverse_q;
  logic [6:0] column_addr_q;
  logic [5:0] row_addr_q, start_line_q, mux_ratio_q, display_offset_q;
  logic [3:0] segment_discharge_level_q;
  int         n_errors = 0;
  int         comparisons = 0;
  int         cycles = 0;

  localparam logic [7:0] OPS [9] = '{oled_cmd_pkg::CMD_PRE_LEVEL, oled_cmd_pkg::CMD_CONTRAST,
    oled_cmd_pkg::CMD_MUX_RATIO, oled_cmd_pkg::CMD_DCDC, oled_cmd_pkg::CMD_ROW_ADDR,
    oled_cmd_pkg::CMD_OFFSET, oled_cmd_pkg::CMD_CLK_DIV, oled_cmd_pkg::CMD_PRE_PERIOD,
    oled_cmd_pkg::CMD_VCOM_LEVEL};
  localparam logic [7:0] POR [9] = '{8'h35, 8'h80, 8'h3F, 8'h81, 8'h00, 8'h00, 8'h50, 8'h22, 8'h35};
  localparam logic [7:0] PAR [9] = '{8'h3C, 8'hFF, 8'hC0, 8'h8B, 8'hC2, 8'h50, 8'hF3, 8'h1F, 8'h00};
  localparam logic [7:0] EXP [9] = '{8'h3C, 8'hFF, 8'h00, 8'h8B, 8'h02, 8'h10, 8'hF3, 8'h1F, 8'h00};

  host_model host (
    .sys_clk         (sys_clk),
    .wr_stb          (wr_stb),
    .rd_stb          (rd_stb),
    .cmd_data_select (cds),
    .wr_data         (wr_data),
    .serial_mode     (serial_mode),
    .internal_busy   (internal_busy),
    .rd_data_q       (rd_data_q),
    .rd_valid_q      (rd_valid_q)
  );

  oled_cmd_decoder dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_data_select(cds),
    .wr_data(wr_data), .serial_mode(serial_mode), .internal_busy(internal_busy),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .cmd_rejected_q(cmd_rejected_q),
    .busy_q(busy_q), .column_addr_q(column_addr_q), .row_addr_q(row_addr_q),
    .rmw_active_q(rmw_active_q), .start_line_q(start_line_q), .contrast_q(contrast_q),
    .seg_remap_q(seg_remap_q), .mux_ratio_q(mux_ratio_q), .dcdc_ctrl_q(dcdc_ctrl_q),
    .display_offset_q(display_offset_q), .clk_div_q(clk_div_q), .pre_period_q(pre_period_q),
    .vcom_level_q(vcom_level_q), .pre_level_q(pre_level_q),
    .segment_discharge_level_q(segment_discharge_level_q), .display_on_q(display_on_q),
    .scan_reverse_q(scan_reverse_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // The whole run takes a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report;
    $display("Counts: %0d mismatches in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic rejected(output logic seen);
    seen = 1'b0;
    repeat (4) begin
      @(negedge sys_clk);
      if (cmd_rejected_q === 1'b1) seen = 1'b1;
    end
  endtask

  function automatic logic [7:0] setting(int i);
    case (i)
      0: return pre_level_q;
      1: return contrast_q;
      2: return {2'b00, mux_ratio_q};
      3: return dcdc_ctrl_q;
      4: return {2'b00, row_addr_q};
      5: return {2'b00, display_offset_q};
      6: return clk_div_q;
      7: return pre_period_q;
      default: return vcom_level_q;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] rd;
    logic       ok;
    logic       seen;
    rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    for (int i = 0; i < 9; i++) chk(setting(i), POR[i]);
    chk({2'b00, start_line_q}, 8'h00);
    chk({1'b0, column_addr_q}, 8'h00);
    chk({4'h0, segment_discharge_level_q}, 8'h00);
    chk({7'h00, seg_remap_q}, 8'h00);
    chk({7'h00, display_on_q}, 8'h00);
    chk({7'h00, scan_reverse_q}, 8'h00);
    chk({7'h00, busy_q}, 8'h01);
    // Commands sent while reset busy is up must be dropped whole.
    host.put(1'b0, oled_cmd_pkg::CMD_CONTRAST);
    rejected(seen);
    chk({7'h00, seen}, 8'h01);
    for (int i = 0; i < 40 && busy_q !== 1'b0; i++) @(negedge sys_clk);
    chk({7'h00, busy_q}, 8'h00);
    chk(contrast_q, 8'h80);
    host.get(1'b0, rd, ok);
    chk(rd & 8'hC7, 8'h40);
    // Parameters that look like commands, such as 3Ch, must be taken as data.
    for (int i = 0; i < 9; i++) begin
      host.put(1'b0, OPS[i]);
      host.put(1'b0, PAR[i]);
    end
    settle();
    for (int i = 0; i < 9; i++) chk(setting(i), EXP[i]);
    chk({4'h0, segment_discharge_level_q}, 8'h00);
    host.put(1'b0, 8'h3A);
    host.put(1'b0, 8'h45);
    host.put(1'b0, 8'hA1);
    host.put(1'b0, 8'h05);
    host.put(1'b0, 8'h11);
    host.put(1'b0, 8'hAF);
    host.put(1'b0, 8'hC8);
    settle();
    chk({4'h0, segment_discharge_level_q}, 8'h0A);
    chk({2'b00, start_line_q}, 8'h05);
    chk({7'h00, seg_remap_q}, 8'h01);
    chk({1'b0, column_addr_q}, 8'h15);
    chk({7'h00, display_on_q}, 8'h01);
    chk({7'h00, scan_reverse_q}, 8'h01);
    host.put(1'b0, 8'hA0);
    host.put(1'b0, 8'hC0);
    settle();
    chk({7'h00, seg_remap_q}, 8'h00);
    chk({7'h00, scan_reverse_q}, 8'h00);
    host.get(1'b0, rd, ok);
    chk(rd & 8'hC7, 8'h00);
    // Internal busy blocks commands just as reset busy does.
    host.set_lines(1'b0, 1'b1);
    repeat (3) @(negedge sys_clk);
    host.get(1'b0, rd, ok);
    chk(rd & 8'hC7, 8'h80);
    host.put(1'b0, 8'h3F);
    rejected(seen);
    chk({7'h00, seen}, 8'h01);
    chk({4'h0, segment_discharge_level_q}, 8'h0A);
    host.set_lines(1'b0, 1'b0);
    repeat (3) @(negedge sys_clk);
    host.put(1'b1, 8'hA5);
    host.put(1'b1, 8'h5A);
    host.put(1'b1, 8'hC3);
    settle();
    chk({1'b0, column_addr_q}, 8'h18);
    host.put(1'b0, 8'h05);
    host.put(1'b0, 8'h11);
    host.get(1'b1, rd, ok);
    host.get(1'b1, rd, ok);
    chk(rd, 8'h5A);
    host.get(1'b1, rd, ok);
    chk(rd, 8'hC3);
    chk({1'b0, column_addr_q}, 8'h18);
    host.put(1'b0, 8'h05);
    host.put(1'b0, 8'h11);
    host.put(1'b0, oled_cmd_pkg::CMD_RMW_START);
    host.get(1'b1, rd, ok);
    host.get(1'b1, rd, ok);
    chk(rd, 8'hA5);
    chk({1'b0, column_addr_q}, 8'h15);
    host.put(1'b1, 8'h77);
    settle();
    chk({1'b0, column_addr_q}, 8'h16);
    chk({7'h00, rmw_active_q}, 8'h01);
    host.put(1'b0, oled_cmd_pkg::CMD_RMW_END);
    settle();
    chk({1'b0, column_addr_q}, 8'h15);
    chk({7'h00, rmw_active_q}, 8'h00);
    host.get(1'b1, rd, ok);
    chk(rd, 8'h77);
    // Over the serial interface a data read gets no answer and moves nothing.
    host.set_lines(1'b1, 1'b0);
    host.get(1'b1, rd, ok);
    chk({7'h00, ok}, 8'h00);
    chk({1'b0, column_addr_q}, 8'h16);
    host.set_lines(1'b0, 1'b0);
    final_report();
  end
endmodule

// [inc/oled_cmd_pkg.sv]
/*
  Shared constants of the OLED command decoder: command codes, field widths,
  power-on values and timing counts.
  Assumes nothing of its surroundings; included before every design file.
*/
package oled_cmd_pkg;

  // Address widths of the display RAM, one byte holds two 4-bit pixels.
  localparam int unsigned COL_W = 7;
  localparam int unsigned ROW_W = 6;

  // Single-byte command codes and patterns.
  localparam logic [7:0] CMD_RMW_START  = 8'hE0;
  localparam logic [7:0] CMD_RMW_END    = 8'hEE;
  localparam logic [7:0] CMD_NOP        = 8'hE3;

  // First bytes of two-byte commands.
  localparam logic [7:0] CMD_CONTRAST   = 8'h81;
  localparam logic [7:0] CMD_MUX_RATIO  = 8'hA8;
  localparam logic [7:0] CMD_DCDC       = 8'hAD;
  localparam logic [7:0] CMD_ROW_ADDR   = 8'hB0;
  localparam logic [7:0] CMD_OFFSET     = 8'hD3;
  localparam logic [7:0] CMD_CLK_DIV    = 8'hD5;
  localparam logic [7:0] CMD_PRE_PERIOD = 8'hD9;
  localparam logic [7:0] CMD_VCOM_LEVEL = 8'hDB;
  localparam logic [7:0] CMD_PRE_LEVEL  = 8'hDC;

  // Power-on values.
  localparam logic [7:0] POR_CONTRAST   = 8'h80;
  localparam logic [5:0] POR_MUX_RATIO  = 6'h3F;
  localparam logic [7:0] POR_DCDC       = 8'h81;
  localparam logic [7:0] POR_CLK_DIV    = 8'h50;
  localparam logic [7:0] POR_PRE_PERIOD = 8'h22;
  localparam logic [7:0] POR_VCOM_LEVEL = 8'h35;
  localparam logic [7:0] POR_PRE_LEVEL  = 8'h35;

  // Status byte layout.
  localparam int unsigned STAT_BUSY_BIT  = 7;
  localparam int unsigned STAT_OFF_BIT   = 6;

  // Busy time after reset, longest figure rounded down to whole cycles.
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned RESET_BUSY_NS     = 1000;
  localparam int unsigned BUSY_CNT_W        = 5;
  localparam logic [BUSY_CNT_W-1:0] RESET_BUSY_CYCLES = BUSY_CNT_W'(RESET_BUSY_NS / CLK_PERIOD_NS);

  typedef enum logic [0:0] {
    PH_CMD   = 1'b0,
    PH_PARAM = 1'b1
  } phase_t;

endpackage
